// ==== rtl/ledfm_pkg.sv ====
package ledfm_pkg;
  // Number of LED output channels handled by the block.
  localparam int          CHANNELS        = 24;
  // Fault pin pulse length and its cycle count at the 100 MHz system clock.
  localparam int          CLK_MHZ         = 100;
  localparam int          PULSE_US        = 50;
  localparam int          PULSE_CYCLES    = PULSE_US * CLK_MHZ;
  localparam int          PULSE_CNT_W     = 13;
  // Width of the non-volatile checksum words.
  localparam int          CRC_W           = 8;
  // Reset value of the latched flags other than the reset and error flags.
  localparam logic        FLAG_RST        = 1'h0;
  // Device states, one-hot.
  typedef enum logic [3:0] {
    LEDFM_POR      = 4'h1,
    LEDFM_INIT     = 4'h2,
    LEDFM_NORMAL   = 4'h4,
    LEDFM_FAILSAFE = 4'h8
  } ledfm_state_t;
endpackage

// ==== rtl/ledfm_pulse.sv ====
`timescale 1ns/10ps
`default_nettype none
// One-shot timer for the fault pin pulse; a new trigger restarts it.
module ledfm_pulse #(
  parameter int CYCLES = 5000,
  parameter int CNT_W  = 13
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      active
);
  logic [CNT_W-1:0] cnt_q;

  // Counts down from the full length; active while non-zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (trigger) begin
      cnt_q <= CNT_W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  assign active = (cnt_q != '0);
endmodule
`default_nettype wire

// ==== rtl/ledfm_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Rail below threshold: reset state, flags, pin low.
// - Rails good again: go to initialization automatically.
// - Clear-reset command clears reset and error flags.
// - Low supply: flag, pulse pin, disable open and single-short diagnostics.
// - Undervoltage: outputs off, flag, pin held low.
// - Reference fault: flag, pin low, outputs kept except in fail-safe.
// - Overtemperature: outputs off, flag, pin held low.
// - Thermal shutdown: regulator off, reset flag, pin low.
// - LED faults gated by enables, pulse width; open and single short also by supply.
// - Single short needs enable; LED fault pulses pin.
// - Checksum mismatch: flag and pulse pin only.
// - Watchdog overflow enters fail-safe; command leaves it.
// - Fail-safe keeps detecting and reporting all faults.
// - Non-volatile bit selects fail-safe LED policy.
// - All-off policy: any LED fault kills all.
// - Failed-only policy: only faulty channel goes off.
// - Flags stay readable in fail-safe.
// - Clear-fault command clears non-reset flags except the fail-safe flag.
// - Mask suppresses error, output flag, pin action.
module ledfm_top
  import ledfm_pkg::*;
#(
  parameter int NCH = ledfm_pkg::CHANNELS
) (
  input  wire logic                         CLK_SYS,
  input  wire logic                         RESET_N,
  input  wire logic                         VBAT_LOW,
  input  wire logic                         REGULATOR_RAIL_LOW,
  input  wire logic                         LOW_SUPPLY,
  input  wire logic                         SUPPLY_UV,
  input  wire logic                         REF_FAULT,
  input  wire logic                         THERMAL_WARN,
  input  wire logic                         THERMAL_PROTECT,
  input  wire logic                         THERMAL_SHUTDOWN,
  input  wire logic [NCH-1:0]               OPEN_DET,
  input  wire logic [NCH-1:0]               SHORT_DET,
  input  wire logic [NCH-1:0]               SINGLE_SHORT_DET,
  input  wire logic [NCH-1:0]               OPEN_PULSE_OK,
  input  wire logic [NCH-1:0]               SHORT_PULSE_OK,
  input  wire logic [NCH-1:0]               SINGLE_PULSE_OK,
  input  wire logic [NCH-1:0]               CHANNEL_ENABLE_BIT,
  input  wire logic [NCH-1:0]               CHANNEL_DIAG_ENABLE_BIT,
  input  wire logic                         SINGLE_SHORT_DETECT_ENABLE,
  input  wire logic [ledfm_pkg::CRC_W-1:0]  COMPUTED_NVM_CHECKSUM,
  input  wire logic [ledfm_pkg::CRC_W-1:0]  STORED_NVM_CHECKSUM,
  input  wire logic                         CHECKSUM_VALID,
  input  wire logic                         WATCHDOG_OVERFLOW,
  input  wire logic                         ALL_CHANNELS_OFF_POLICY,
  input  wire logic                         INIT_DONE,
  input  wire logic                         CLEAR_RESET_FLAG_CMD,
  input  wire logic                         CLEAR_FAULT_CMD,
  input  wire logic                         LEAVE_FAILSAFE_CMD,
  input  wire logic                         LOW_SUPPLY_MASK,
  input  wire logic                         SUPPLY_UV_MASK,
  input  wire logic                         REF_MASK,
  input  wire logic                         THERMAL_WARN_MASK,
  input  wire logic                         THERMAL_PROTECT_MASK,
  input  wire logic                         NVM_CHECKSUM_MASK,
  input  wire logic                         OPEN_FAULT_MASK,
  input  wire logic                         SHORT_FAULT_MASK,
  input  wire logic                         SINGLE_SHORT_MASK,
  output logic                              RESET_FLAG,
  output logic                              ERROR_FLAG,
  output logic                              LOW_SUPPLY_FLAG,
  output logic                              SUPPLY_UNDERVOLTAGE_FLAG,
  output logic                              REF_FLAG,
  output logic                              THERMAL_WARNING_FLAG,
  output logic                              THERMAL_PROTECT_FLAG,
  output logic                              NVM_CHECKSUM_FLAG,
  output logic                              FAILSAFE_ENTERED_FLAG,
  output logic                              OUTPUT_FLAG,
  output logic [NCH-1:0]                    CHANNEL_OPEN_FLAG,
  output logic [NCH-1:0]                    CHANNEL_SHORT_FLAG,
  output logic [NCH-1:0]                    CHANNEL_SINGLE_SHORT_FLAG,
  output logic [NCH-1:0]                    CHANNEL_ON,
  output logic                              REGULATOR_OFF,
  output logic                              CLEAR_RESET_FLAG_CMD_BIT,
  output logic                              CLEAR_FAULT_CMD_BIT,
  output logic [3:0]                        DEVICE_STATE,
  output logic                              FAULT_PIN_OUT,
  output logic                              FAULT_PIN_OE
);
  ledfm_state_t     state_q;
  logic [2:0]       sync_vbat_q;
  logic [2:0]       sync_ldo_q;
  logic [2:0]       sync_lows_q;
  logic [2:0]       sync_uv_q;
  logic [2:0]       sync_ref_q;
  logic [2:0]       sync_tw_q;
  logic [2:0]       sync_tp_q;
  logic [2:0]       sync_tsd_q;
  logic             vbat_low;
  logic             ldo_low;
  logic             lows;
  logic             uv;
  logic             ref_f;
  logic             tw;
  logic             tp;
  logic             tsd;
  logic             rail_bad;
  logic             diag_supply_ok;
  logic [NCH-1:0]   diag_on;
  logic [NCH-1:0]   open_ev;
  logic [NCH-1:0]   short_ev;
  logic [NCH-1:0]   sls_ev;
  logic [NCH-1:0]   led_fail_q;
  logic             crc_ev;
  logic             lows_q;
  logic             tw_q;
  logic             crc_q;
  logic [NCH-1:0]   open_q;
  logic [NCH-1:0]   short_q;
  logic [NCH-1:0]   sls_q;
  logic             err_set;
  logic             out_set;
  logic             pulse_trig;
  logic             pulse_active;
  logic             pin_const;
  logic             clr_rst_q;
  logic             clr_flt_q;
  logic             in_fs;

  // A change counts once the second and third stages agree.
  function automatic logic sync_val(input logic [2:0] s, input logic prev);
    sync_val = (s[2] == s[1]) ? s[1] : prev;
  endfunction

  // Three-stage synchronisers for the asynchronous monitor levels.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_vbat_q <= 3'h0;
      sync_ldo_q  <= 3'h0;
      sync_lows_q <= 3'h0;
      sync_uv_q   <= 3'h0;
      sync_ref_q  <= 3'h0;
      sync_tw_q   <= 3'h0;
      sync_tp_q   <= 3'h0;
      sync_tsd_q  <= 3'h0;
    end else begin
      sync_vbat_q <= {sync_vbat_q[1:0], VBAT_LOW};
      sync_ldo_q  <= {sync_ldo_q[1:0], REGULATOR_RAIL_LOW};
      sync_lows_q <= {sync_lows_q[1:0], LOW_SUPPLY};
      sync_uv_q   <= {sync_uv_q[1:0], SUPPLY_UV};
      sync_ref_q  <= {sync_ref_q[1:0], REF_FAULT};
      sync_tw_q   <= {sync_tw_q[1:0], THERMAL_WARN};
      sync_tp_q   <= {sync_tp_q[1:0], THERMAL_PROTECT};
      sync_tsd_q  <= {sync_tsd_q[1:0], THERMAL_SHUTDOWN};
    end
  end

  // Filtered levels; they hold while stages two and three disagree.
  logic [7:0] lvl_q;
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      lvl_q <= 8'h00;
    end else begin
      lvl_q[0] <= sync_val(sync_vbat_q, lvl_q[0]);
      lvl_q[1] <= sync_val(sync_ldo_q, lvl_q[1]);
      lvl_q[2] <= sync_val(sync_lows_q, lvl_q[2]);
      lvl_q[3] <= sync_val(sync_uv_q, lvl_q[3]);
      lvl_q[4] <= sync_val(sync_ref_q, lvl_q[4]);
      lvl_q[5] <= sync_val(sync_tw_q, lvl_q[5]);
      lvl_q[6] <= sync_val(sync_tp_q, lvl_q[6]);
      lvl_q[7] <= sync_val(sync_tsd_q, lvl_q[7]);
    end
  end

  assign vbat_low = lvl_q[0];
  assign ldo_low  = lvl_q[1];
  assign lows     = lvl_q[2];
  assign uv       = lvl_q[3];
  assign ref_f    = lvl_q[4];
  assign tw       = lvl_q[5];
  assign tp       = lvl_q[6];
  assign tsd      = lvl_q[7];
  assign rail_bad = vbat_low | ldo_low | tsd;
  assign in_fs    = (state_q == LEDFM_FAILSAFE);

  // Device state: any bad rail forces the reset state from anywhere.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= LEDFM_POR;
    end else if (rail_bad) begin
      state_q <= LEDFM_POR;
    end else begin
      case (state_q)
        LEDFM_POR:      state_q <= LEDFM_INIT;
        LEDFM_INIT:     state_q <= INIT_DONE ? LEDFM_NORMAL : LEDFM_INIT;
        LEDFM_NORMAL:   state_q <= WATCHDOG_OVERFLOW ? LEDFM_FAILSAFE : LEDFM_NORMAL;
        LEDFM_FAILSAFE: state_q <= LEAVE_FAILSAFE_CMD ? LEDFM_NORMAL : LEDFM_FAILSAFE;
        default:        state_q <= LEDFM_POR;
      endcase
    end
  end

  // Qualified LED fault events; low supply blocks open and single short.
  assign diag_supply_ok = ~lows;
  assign diag_on  = CHANNEL_ENABLE_BIT & CHANNEL_DIAG_ENABLE_BIT;
  assign open_ev  = diag_on & OPEN_PULSE_OK & OPEN_DET & {NCH{diag_supply_ok}};
  assign short_ev = diag_on & SHORT_PULSE_OK & SHORT_DET;
  assign sls_ev   = diag_on & SINGLE_PULSE_OK & SINGLE_SHORT_DET
                    & {NCH{diag_supply_ok & SINGLE_SHORT_DETECT_ENABLE}};
  assign crc_ev   = CHECKSUM_VALID & (COMPUTED_NVM_CHECKSUM != STORED_NVM_CHECKSUM);

  // Self-clearing command bits: each is seen for exactly one cycle.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      clr_rst_q <= 1'h0;
      clr_flt_q <= 1'h0;
    end else begin
      clr_rst_q <= CLEAR_RESET_FLAG_CMD & ~clr_rst_q;
      clr_flt_q <= CLEAR_FAULT_CMD & ~clr_flt_q;
    end
  end

  // Reset flag: set in the reset state, cleared only by its own command.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_FLAG <= 1'h1;
    end else if (state_q == LEDFM_POR || rail_bad) begin
      RESET_FLAG <= 1'h1;
    end else if (clr_rst_q) begin
      RESET_FLAG <= 1'h0;
    end
  end

  // Latched non-reset flags; the set term wins over a clear in the same cycle.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      LOW_SUPPLY_FLAG          <= FLAG_RST;
      SUPPLY_UNDERVOLTAGE_FLAG <= FLAG_RST;
      REF_FLAG                 <= FLAG_RST;
      THERMAL_WARNING_FLAG     <= FLAG_RST;
      THERMAL_PROTECT_FLAG     <= FLAG_RST;
      NVM_CHECKSUM_FLAG        <= FLAG_RST;
      CHANNEL_OPEN_FLAG        <= '0;
      CHANNEL_SHORT_FLAG       <= '0;
      CHANNEL_SINGLE_SHORT_FLAG <= '0;
    end else begin
      LOW_SUPPLY_FLAG          <= lows  | (LOW_SUPPLY_FLAG & ~clr_flt_q);
      SUPPLY_UNDERVOLTAGE_FLAG <= uv    | (SUPPLY_UNDERVOLTAGE_FLAG & ~clr_flt_q);
      REF_FLAG                 <= ref_f | (REF_FLAG & ~clr_flt_q);
      THERMAL_WARNING_FLAG     <= tw    | (THERMAL_WARNING_FLAG & ~clr_flt_q);
      THERMAL_PROTECT_FLAG     <= tp    | (THERMAL_PROTECT_FLAG & ~clr_flt_q);
      NVM_CHECKSUM_FLAG        <= crc_ev | (NVM_CHECKSUM_FLAG & ~clr_flt_q);
      CHANNEL_OPEN_FLAG  <= open_ev | (CHANNEL_OPEN_FLAG & {NCH{~clr_flt_q}});
      CHANNEL_SHORT_FLAG <= short_ev | (CHANNEL_SHORT_FLAG & {NCH{~clr_flt_q}});
      CHANNEL_SINGLE_SHORT_FLAG <= sls_ev
                                   | (CHANNEL_SINGLE_SHORT_FLAG & {NCH{~clr_flt_q}});
    end
  end

  // Unmasked contributions to the summary flags.
  assign out_set = (|open_ev & ~OPEN_FAULT_MASK) | (|short_ev & ~SHORT_FAULT_MASK)
                 | (|sls_ev & ~SINGLE_SHORT_MASK);
  assign err_set = (lows & ~LOW_SUPPLY_MASK) | (uv & ~SUPPLY_UV_MASK)
                 | (ref_f & ~REF_MASK) | (tw & ~THERMAL_WARN_MASK)
                 | (tp & ~THERMAL_PROTECT_MASK) | (crc_ev & ~NVM_CHECKSUM_MASK)
                 | out_set;

  // Summary flags; reset-type faults set the error flag regardless of masks.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ERROR_FLAG  <= 1'h1;
      OUTPUT_FLAG <= FLAG_RST;
    end else begin
      ERROR_FLAG  <= (state_q == LEDFM_POR) | rail_bad | err_set
                   | (ERROR_FLAG & ~clr_flt_q & ~clr_rst_q);
      OUTPUT_FLAG <= out_set | (OUTPUT_FLAG & ~clr_flt_q);
    end
  end

  // Fail-safe flag follows entry; the leave command clears it.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      FAILSAFE_ENTERED_FLAG <= FLAG_RST;
    end else if (state_q == LEDFM_NORMAL && WATCHDOG_OVERFLOW && !rail_bad) begin
      FAILSAFE_ENTERED_FLAG <= 1'h1;
    end else if (in_fs && LEAVE_FAILSAFE_CMD) begin
      FAILSAFE_ENTERED_FLAG <= 1'h0;
    end
  end

  // Fail-safe LED shutoff memory; it is dropped on return to normal.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      led_fail_q <= '0;
    end else if (!in_fs) begin
      led_fail_q <= '0;
    end else if (ALL_CHANNELS_OFF_POLICY && |(open_ev | short_ev | sls_ev)) begin
      led_fail_q <= '1;
    end else begin
      led_fail_q <= led_fail_q | open_ev | short_ev | sls_ev;
    end
  end

  // Outputs: undervoltage, thermal protection and fail-safe reference fault
  // switch channels off; normal-state LED faults leave them alone.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      CHANNEL_ON    <= '0;
      REGULATOR_OFF <= 1'h0;
    end else begin
      REGULATOR_OFF <= tsd;
      if ((state_q != LEDFM_NORMAL && !in_fs) || uv || tp || (in_fs && ref_f)) begin
        CHANNEL_ON <= '0;
      end else begin
        CHANNEL_ON <= CHANNEL_ENABLE_BIT & ~led_fail_q;
      end
    end
  end

  // Pulse requests from transient faults, taken on their rising edge only.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      lows_q  <= 1'h0;
      tw_q    <= 1'h0;
      crc_q   <= 1'h0;
      open_q  <= '0;
      short_q <= '0;
      sls_q   <= '0;
    end else begin
      lows_q  <= lows;
      tw_q    <= tw;
      crc_q   <= crc_ev;
      open_q  <= open_ev;
      short_q <= short_ev;
      sls_q   <= sls_ev;
    end
  end

  assign pulse_trig = (lows & ~lows_q & ~LOW_SUPPLY_MASK)
                    | (tw & ~tw_q & ~THERMAL_WARN_MASK)
                    | (crc_ev & ~crc_q & ~NVM_CHECKSUM_MASK)
                    | (|(open_ev & ~open_q) & ~OPEN_FAULT_MASK)
                    | (|(short_ev & ~short_q) & ~SHORT_FAULT_MASK)
                    | (|(sls_ev & ~sls_q) & ~SINGLE_SHORT_MASK);

  ledfm_pulse #(
    .CYCLES (PULSE_CYCLES),
    .CNT_W  (PULSE_CNT_W)
  ) u_pulse (
    .clk     (CLK_SYS),
    .rst_n   (RESET_N),
    .trigger (pulse_trig),
    .active  (pulse_active)
  );

  // Constant pull-down requests; watchdog overflow never touches the pin.
  assign pin_const = (state_q == LEDFM_POR) | tsd
                   | (uv & ~SUPPLY_UV_MASK) | (ref_f & ~REF_MASK)
                   | (tp & ~THERMAL_PROTECT_MASK);

  // Open-drain pin: only ever driven low; constant request dominates.
  assign FAULT_PIN_OUT = 1'h0;
  assign FAULT_PIN_OE  = pin_const | pulse_active;

  assign CLEAR_RESET_FLAG_CMD_BIT = clr_rst_q;
  assign CLEAR_FAULT_CMD_BIT      = clr_flt_q;
  assign DEVICE_STATE             = state_q;
endmodule
`default_nettype wire

// ==== testbench/ledfm_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the fault manager; each ties an output to its cause, except the self-clearing and pin-level checks.
module ledfm_top_properties
  import ledfm_pkg::*;
#(
  parameter int NCH = CHANNELS
) (
  input wire logic           CLK_SYS,
  input wire logic           RESET_N,
  input wire logic           SUPPLY_UV,
  input wire logic           SUPPLY_UV_MASK,
  input wire logic           THERMAL_PROTECT,
  input wire logic           REF_FAULT,
  input wire logic           REF_MASK,
  input wire logic           WATCHDOG_OVERFLOW,
  input wire logic           ALL_CHANNELS_OFF_POLICY,
  input wire logic           RESET_FLAG,
  input wire logic           ERROR_FLAG,
  input wire logic           FAILSAFE_ENTERED_FLAG,
  input wire logic [NCH-1:0] CHANNEL_SHORT_FLAG,
  input wire logic [NCH-1:0] CHANNEL_ON,
  input wire logic           CLEAR_RESET_FLAG_CMD_BIT,
  input wire logic           CLEAR_FAULT_CMD_BIT,
  input wire logic [3:0]     DEVICE_STATE,
  input wire logic           FAULT_PIN_OUT,
  input wire logic           FAULT_PIN_OE
);
  // Reduced form kept as a net so the sampled functions see a plain signal.
  wire any_short = |CHANNEL_SHORT_FLAG;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  property p_por_pin;
    DEVICE_STATE == LEDFM_POR |-> FAULT_PIN_OE && RESET_FLAG && ERROR_FLAG;
  endproperty
  a_por_pin: assert property (p_por_pin) else $error("reset state pin or flags wrong");
  property p_init_flags;
    $past(DEVICE_STATE) == LEDFM_POR && DEVICE_STATE == LEDFM_INIT |-> RESET_FLAG && ERROR_FLAG;
  endproperty
  a_init_flags: assert property (p_init_flags) else $error("flags lost entering init");
  property p_clr_reset_self;
    CLEAR_RESET_FLAG_CMD_BIT |=> !CLEAR_RESET_FLAG_CMD_BIT;
  endproperty
  a_clr_reset_self: assert property (p_clr_reset_self) else $error("reset clear bit stuck");
  property p_clr_fault_self;
    CLEAR_FAULT_CMD_BIT |=> !CLEAR_FAULT_CMD_BIT;
  endproperty
  a_clr_fault_self: assert property (p_clr_fault_self) else $error("fault clear bit stuck");
  property p_uv_off;
    SUPPLY_UV [*8] |-> CHANNEL_ON == '0 && (SUPPLY_UV_MASK || FAULT_PIN_OE);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage not acted on");
  property p_tp_off;
    THERMAL_PROTECT [*8] |-> CHANNEL_ON == '0;
  endproperty
  a_tp_off: assert property (p_tp_off) else $error("outputs on while overheated");
  property p_ref_pin;
    (REF_FAULT && !REF_MASK && DEVICE_STATE == LEDFM_NORMAL) [*8] |-> FAULT_PIN_OE;
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference fault pin released");
  property p_wd_fs;
    $rose(WATCHDOG_OVERFLOW) && DEVICE_STATE == LEDFM_NORMAL
      |-> ##[1:2] DEVICE_STATE == LEDFM_FAILSAFE && FAILSAFE_ENTERED_FLAG;
  endproperty
  a_wd_fs: assert property (p_wd_fs) else $error("watchdog did not enter fail-safe");
  property p_all_off;
    DEVICE_STATE == LEDFM_FAILSAFE && ALL_CHANNELS_OFF_POLICY && $rose(any_short)
      |-> ##[0:2] CHANNEL_ON == '0;
  endproperty
  a_all_off: assert property (p_all_off) else $error("all-off policy left outputs on");
  property p_od_low;
    FAULT_PIN_OUT == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("fault pin drives high");
  c_init: cover property ($past(DEVICE_STATE) == LEDFM_POR && DEVICE_STATE == LEDFM_INIT);
  c_fs: cover property (DEVICE_STATE == LEDFM_FAILSAFE);
  c_clr: cover property (CLEAR_FAULT_CMD_BIT);
endmodule
bind ledfm_top ledfm_top_properties #(.NCH(NCH)) i_ledfm_top_properties (.*);
`default_nettype wire

// ==== testbench/ledfm_master.sv ====
`timescale 1ns/10ps
`default_nettype none
// Controller model: writes command bits and times low stretches of the pin.
module ledfm_master (
  input wire logic clk,
  input wire logic fault_pin_n,
  output logic     clr_fault,
  output logic     clr_reset,
  output logic     leave_fs,
  output int       low_len
);
  int cnt = 0;
  initial begin
    clr_fault = 1'b0;
    clr_reset = 1'b0;
    leave_fs = 1'b0;
    low_len = 0;
  end
  // Length of the last low stretch, so the bench can judge pulse width.
  always @(posedge clk) begin
    if (!fault_pin_n) cnt <= cnt + 1;
    else begin
      if (cnt != 0) low_len <= cnt;
      cnt <= 0;
    end
  end
  // A command is a written one, dropped after one cycle like a register write.
  task automatic cmd(input int which);
    @(posedge clk);
    case (which)
      0: clr_fault <= 1'b1;
      1: clr_reset <= 1'b1;
      default: leave_fs <= 1'b1;
    endcase
    @(posedge clk);
    clr_fault <= 1'b0;
    clr_reset <= 1'b0;
    leave_fs <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_ledfm_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk((g) === (e), 32'(g), 32'(e))
module tb_ledfm_top;
  import ledfm_pkg::*;
  logic clk = 0, rst_n = 0, vbat = 0, lows = 0, uv = 0, ref_f = 0, tp = 0, tsd = 0;
  logic sls_en = 1, ck_ok = 0, wd = 0, pol = 0, init_done = 0, ldo = 0, tw = 0;
  logic [CHANNELS-1:0] det [3] = '{3{'0}};
  logic [CHANNELS-1:0] en = 0, den = '1, pok = '1;
  logic [CRC_W-1:0] ck_a = 0, ck_b = 0;
  logic [8:0] masks = 0;
  logic [CHANNELS-1:0] fl [3], chon;
  logic rflag, eflag, lsf, uvf, tpf, nvf, fsf, of, regoff, cfb, crb, pout, oe, clf, clr, lfs;
  logic [3:0] st;
  logic rff, twf;
  int n_mismatch = 0, num_checks = 0, cyc = 0, low_len;
  wire pin_n = oe ? pout : 1'b1; // Pulled up while nobody sinks it.
  always #5 clk = ~clk;
  ledfm_top i_ledfm_top (.CLK_SYS(clk), .RESET_N(rst_n), .VBAT_LOW(vbat),
    .REGULATOR_RAIL_LOW(ldo), .LOW_SUPPLY(lows), .SUPPLY_UV(uv), .REF_FAULT(ref_f),
    .THERMAL_WARN(tw), .THERMAL_PROTECT(tp), .THERMAL_SHUTDOWN(tsd), .OPEN_DET(det[0]),
    .SHORT_DET(det[1]), .SINGLE_SHORT_DET(det[2]), .OPEN_PULSE_OK(pok), .SHORT_PULSE_OK(pok),
    .SINGLE_PULSE_OK(pok), .CHANNEL_ENABLE_BIT(en), .CHANNEL_DIAG_ENABLE_BIT(den),
    .SINGLE_SHORT_DETECT_ENABLE(sls_en), .COMPUTED_NVM_CHECKSUM(ck_a),
    .STORED_NVM_CHECKSUM(ck_b), .CHECKSUM_VALID(ck_ok), .WATCHDOG_OVERFLOW(wd),
    .ALL_CHANNELS_OFF_POLICY(pol), .INIT_DONE(init_done), .CLEAR_RESET_FLAG_CMD(clr),
    .CLEAR_FAULT_CMD(clf), .LEAVE_FAILSAFE_CMD(lfs), .LOW_SUPPLY_MASK(masks[0]),
    .SUPPLY_UV_MASK(masks[1]), .REF_MASK(masks[2]), .THERMAL_WARN_MASK(masks[3]),
    .THERMAL_PROTECT_MASK(masks[4]), .NVM_CHECKSUM_MASK(masks[5]), .OPEN_FAULT_MASK(masks[6]),
    .SHORT_FAULT_MASK(masks[7]), .SINGLE_SHORT_MASK(masks[8]), .RESET_FLAG(rflag),
    .ERROR_FLAG(eflag), .LOW_SUPPLY_FLAG(lsf), .SUPPLY_UNDERVOLTAGE_FLAG(uvf), .REF_FLAG(rff),
    .THERMAL_WARNING_FLAG(twf), .THERMAL_PROTECT_FLAG(tpf), .NVM_CHECKSUM_FLAG(nvf),
    .FAILSAFE_ENTERED_FLAG(fsf), .OUTPUT_FLAG(of), .CHANNEL_OPEN_FLAG(fl[0]),
    .CHANNEL_SHORT_FLAG(fl[1]), .CHANNEL_SINGLE_SHORT_FLAG(fl[2]), .CHANNEL_ON(chon),
    .REGULATOR_OFF(regoff), .CLEAR_RESET_FLAG_CMD_BIT(crb), .CLEAR_FAULT_CMD_BIT(cfb),
    .DEVICE_STATE(st), .FAULT_PIN_OUT(pout), .FAULT_PIN_OE(oe));
  ledfm_master i_ledfm_master (.clk(clk), .fault_pin_n(pin_n), .clr_fault(clf),
    .clr_reset(clr), .leave_fs(lfs), .low_len(low_len));
  function automatic void chk(input bit ok, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Pulses run 5000 cycles each, so the ceiling leaves room for about twelve.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end
  // One LED fault on a random channel; masked faults must stay off the pin.
  task automatic led(input int k, input bit m);
    int ch;
    ch = $urandom % CHANNELS;
    masks[6+k] <= m;
    en[ch] <= 1'b1;
    det[k][ch] <= 1'b1;
    step(2);
    det[k][ch] <= 1'b0;
    step(1);
    #1;
    `CHK(fl[k][ch], 1'b1);
    `CHK({of, eflag}, {2{!m}});
    step(5005);
    `CHK(low_len, m ? 0 : PULSE_CYCLES);
    i_ledfm_master.cmd(0);
    step(2);
    #1;
    `CHK({fl[k][ch], of, eflag}, 3'h0);
    i_ledfm_master.low_len = 0;
    $display("led test %0d mask %0d done", k, m);
  endtask
  initial begin
    int ch;
    void'($urandom(32'h88da));
    en = CHANNELS'($urandom);
    step(11);
    #1;
    `CHK({st, rflag, eflag, oe}, {LEDFM_POR, 3'h7});
    @(posedge clk) rst_n <= 1'b1;
    step(3);
    #1;
    `CHK({st, rflag, eflag}, {LEDFM_INIT, 2'h3});
    i_ledfm_master.cmd(1);
    step(2);
    init_done <= 1'b1;
    step(2);
    #1;
    `CHK({st, rflag, eflag}, {LEDFM_NORMAL, 2'h0});
    for (int k = 0; k < 6; k++) led(k % 3, k / 3);
    // Gating: diag enable, pulse width, detect enable, then low supply.
    ch = $urandom % CHANNELS;
    @(posedge clk);
    en[ch] <= 1'b1;
    den[ch] <= 1'b0;
    det[0][ch] <= 1'b1;
    step(3);
    den[ch] <= 1'b1;
    pok[ch] <= 1'b0;
    step(3);
    pok[ch] <= 1'b1;
    det[0][ch] <= 1'b0;
    sls_en <= 1'b0;
    det[2][ch] <= 1'b1;
    step(3);
    #1;
    `CHK({fl[0][ch], fl[2][ch]}, 2'h0);
    @(posedge clk);
    det[2][ch] <= 1'b0;
    sls_en <= 1'b1;
    masks[0] <= 1'b1;
    lows <= 1'b1;
    step(8);
    det[0][ch] <= 1'b1;
    step(3);
    #1;
    `CHK({fl[0][ch], lsf, eflag}, 3'h2);
    @(posedge clk);
    det[0][ch] <= 1'b0;
    lows <= 1'b0;
    $display("gating test done");
    // Undervoltage then overtemperature: outputs off, pin held, flag sticky.
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      if (k) tp <= 1'b1;
      else uv <= 1'b1;
      step(8);
      i_ledfm_master.cmd(0);
      step(2);
      #1;
      `CHK({chon, oe}, {{CHANNELS{1'b0}}, 1'b1});
      `CHK(k ? tpf : uvf, 1'b1);
      @(posedge clk);
      uv <= 1'b0;
      tp <= 1'b0;
      step(8);
      #1;
      `CHK({chon, oe}, {en, 1'b0});
      i_ledfm_master.cmd(0);
    end
    // Masked thermal warning rides along: own flag only, no pulse on the pin.
    @(posedge clk);
    ref_f <= 1'b1;
    tw <= 1'b1;
    masks[3] <= 1'b1;
    step(8);
    #1;
    `CHK({chon, oe}, {en, 1'b1});
    @(posedge clk);
    ref_f <= 1'b0;
    tw <= 1'b0;
    step(8);
    #1;
    `CHK(oe, 1'b0);
    `CHK({rff, twf}, 2'h3);
    @(posedge clk);
    ck_a <= 8'h5A;
    ck_b <= 8'hA5;
    ck_ok <= 1'b1;
    step(5005);
    #1;
    `CHK({nvf, chon, low_len}, {1'b1, en, PULSE_CYCLES});
    ck_b <= 8'h5A;
    i_ledfm_master.cmd(0);
    $display("supply and checksum tests done");
    // Fail-safe with both LED policies, pin masked so no pulse gets in the way.
    @(posedge clk);
    masks[7] <= 1'b1;
    wd <= 1'b1;
    step(1);
    wd <= 1'b0;
    step(3);
    #1;
    `CHK({st, fsf, oe}, {LEDFM_FAILSAFE, 2'h2});
    // Failed-only first: the all-off memory lasts until fail-safe is left.
    for (int p = 0; p < 2; p++) begin
      ch = $urandom % CHANNELS;
      @(posedge clk);
      pol <= p[0];
      en[ch] <= 1'b1;
      det[1][ch] <= 1'b1;
      step(3);
      #1;
      `CHK(chon, p ? '0 : en & ~(CHANNELS'(1) << ch));
      `CHK(fl[1][ch], 1'b1);
      @(posedge clk) det[1][ch] <= 1'b0;
      i_ledfm_master.cmd(0);
    end
    i_ledfm_master.cmd(2);
    step(2);
    #1;
    `CHK(st, LEDFM_NORMAL);
    $display("fail-safe test done");
    // Rail loss, thermal shutdown and regulator loss all fall back to reset.
    // Init completion is withdrawn so the device rests in init afterwards.
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      init_done <= 1'b0;
      case (k)
        0: vbat <= 1'b1;
        1: tsd <= 1'b1;
        default: ldo <= 1'b1;
      endcase
      step(8);
      #1;
      `CHK({st, rflag, eflag, oe, regoff}, {LEDFM_POR, 3'h7, k == 1});
      @(posedge clk);
      vbat <= 1'b0;
      tsd <= 1'b0;
      ldo <= 1'b0;
      step(8);
      #1;
      `CHK({st, rflag, eflag}, {LEDFM_INIT, 2'h3});
    end
    $display("reset fault test done");
    results();
  end
endmodule
`default_nettype wire
